/* verilog/asdp_consts.svh */
// Register offsets, field positions, reset values and opcode fields of the datapath.
`ifndef ASDP_CONSTS_SVH
`define ASDP_CONSTS_SVH

`define ASDP_OFF_INSTR     8'h00
`define ASDP_OFF_FILE_IN   8'h04
`define ASDP_OFF_FILE_OUT  8'h08
`define ASDP_OFF_ACC       8'h0c
`define ASDP_OFF_STATUS    8'h10
`define ASDP_OFF_PTR0      8'h14
`define ASDP_OFF_PTR1      8'h18

`define ASDP_ST_C          0
`define ASDP_ST_NC         1
`define ASDP_ST_Z          2
`define ASDP_ST_BUSY       3
`define ASDP_ST_WB         4

`define ASDP_FO_ADDR_LSB   8
`define ASDP_ACC_RST       8'h00
`define ASDP_PTR_RST       16'h0000
`define ASDP_INSTR_RST     14'h0000

`define ASDP_GRP_LIT       2'h3
`define ASDP_GRP_FILE      2'h0
`define ASDP_NIB_LADD      4'he
`define ASDP_NIB_LAND      4'h9
`define ASDP_NIB_PADD      4'h1
`define ASDP_NIB_ADDC      4'hd
`define ASDP_NIB_ASR       4'h7
`define ASDP_NIB_RADD      4'h7
`define ASDP_NIB_RAND      4'h5
`define ASDP_IND0_ADDR     7'h00
`define ASDP_IND1_ADDR     7'h01

`define ASDP_RESP_OKAY     2'h0
`define ASDP_RESP_SLVERR   2'h2

`endif

/* verilog/asdp_pkg.sv */
// Types shared by the add and shift datapath.
`default_nettype none
package asdp_pkg;

  typedef struct packed {
    logic z;
    logic nc;
    logic c;
  } asdp_flags_s;

  typedef struct packed {
    logic [7:0]  value;
    asdp_flags_s flags;
  } asdp_sum_s;

  typedef enum logic [2:0] {
    ASDP_IDLE  = 3'b001,
    ASDP_STALL = 3'b010,
    ASDP_EXEC  = 3'b100
  } asdp_state_e;

  typedef logic [13:0] asdp_opcode_t;

endpackage
`default_nettype wire

/* verilog/asdp_core.sv */
// AXI4-Lite controlled execution datapath for add, AND and shift instructions.
//
// Functional notes
// RL1 - Pointer add: signed six-bit literal, no flags.
// RL2 - Pointer pair wraps modulo 65536.
// RL3 - Literal add into accumulator, updates all three flags.
// RL4 - Register add: accumulator plus addressed register.
// RL5 - Target bit zero: accumulator; one: register.
// RL6 - Add with carry includes current carry.
// RL7 - Literal AND into accumulator, zero flag only.
// RL8 - Register AND to chosen target, zero only.
// RL9 - Arithmetic shift right, bit 0 into carry.
// RL10 - Literal add opcode 11 1110, one cycle.
// RL11 - Literal AND opcode 11 1001, one cycle.
// RL12 - Pointer add opcode 11 0001 0nkk.
// RL13 - Indirect access with pointer MSb: extra cycle.
// RL14 - Carry bit 7, nibble carry 3, zero flag.
`timescale 1ns/1ps
`default_nettype none
`include "asdp_consts.svh"
module asdp_core
  import asdp_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [7:0]   awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;
  asdp_opcode_t instr_reg;
  logic [7:0]   file_in_reg;
  logic [7:0]   file_out_reg;
  logic [6:0]   file_addr_reg;
  logic         file_wb_reg;
  logic [7:0]   acc_reg;
  asdp_flags_s  flags_reg;
  logic [15:0]  ptr_reg [2];
  asdp_state_e  state_reg;
  asdp_state_e  state_next;
  logic         wr_do;
  logic         wr_mapped;
  logic         instr_hit;

  // Addition with carry in; carry from bit 7, nibble carry from bit 3.
  function automatic asdp_sum_s add8(input logic [7:0] a, input logic [7:0] b,
                                     input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    asdp_sum_s  r;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.value    = full[7:0];
    r.flags.c  = full[8]; // RL14
    r.flags.nc = low[4]; // RL14
    r.flags.z  = (full[7:0] == 8'h00); // RL14
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_file_op(input asdp_opcode_t op);
    logic r;
    r = 1'b0;
    if (op[13:12] == `ASDP_GRP_FILE) begin
      r = (op[11:8] == `ASDP_NIB_RADD) || (op[11:8] == `ASDP_NIB_RAND);
    end else if (op[13:12] == `ASDP_GRP_LIT) begin
      r = (op[11:8] == `ASDP_NIB_ADDC) || (op[11:8] == `ASDP_NIB_ASR);
    end
    return r;
  endfunction

  // Write channels are taken independently; the write acts once both are held.
  assign wr_do     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign instr_hit = wr_do && awaddr_reg == `ASDP_OFF_INSTR && state_reg == ASDP_IDLE;
  assign wr_mapped = awaddr_reg == `ASDP_OFF_INSTR || awaddr_reg == `ASDP_OFF_FILE_IN ||
                     awaddr_reg == `ASDP_OFF_ACC || awaddr_reg == `ASDP_OFF_STATUS ||
                     awaddr_reg == `ASDP_OFF_PTR0 || awaddr_reg == `ASDP_OFF_PTR1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASDP_RESP_OKAY;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `ASDP_RESP_OKAY : `ASDP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ASDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `ASDP_RESP_OKAY;
      case (s_axi_araddr)
        `ASDP_OFF_INSTR:    s_axi_rdata <= {18'h00000, instr_reg};
        `ASDP_OFF_FILE_IN:  s_axi_rdata <= {24'h000000, file_in_reg};
        `ASDP_OFF_FILE_OUT: s_axi_rdata <= {17'h00000, file_addr_reg, file_out_reg};
        `ASDP_OFF_ACC:      s_axi_rdata <= {24'h000000, acc_reg};
        `ASDP_OFF_STATUS:   s_axi_rdata <= {27'h0000000, file_wb_reg,
                                            state_reg != ASDP_IDLE, flags_reg};
        `ASDP_OFF_PTR0:     s_axi_rdata <= {16'h0000, ptr_reg[0]};
        `ASDP_OFF_PTR1:     s_axi_rdata <= {16'h0000, ptr_reg[1]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ASDP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // An indirect operand whose pointer has its top bit set costs one more cycle.
  always_comb begin
    logic [13:0] op;
    op = wdata_reg[13:0];
    state_next = state_reg;
    case (state_reg)
      ASDP_IDLE: begin
        if (instr_hit) begin
          state_next = ASDP_EXEC;
          if (is_file_op(op) && (op[6:0] == `ASDP_IND0_ADDR || op[6:0] == `ASDP_IND1_ADDR) &&
              ptr_reg[op[0]][15]) begin
            state_next = ASDP_STALL; // RL13
          end
        end
      end
      ASDP_STALL: state_next = ASDP_EXEC; // RL13
      ASDP_EXEC:  state_next = ASDP_IDLE; // RL10 RL11
      default:    state_next = ASDP_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ASDP_IDLE;
      instr_reg <= `ASDP_INSTR_RST;
    end else begin
      state_reg <= state_next;
      if (instr_hit) begin
        instr_reg <= wdata_reg[13:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_in_reg <= 8'h00;
    end else if (wr_do && awaddr_reg == `ASDP_OFF_FILE_IN) begin
      file_in_reg <= 8'(merge({24'h000000, file_in_reg}, wdata_reg, wstrb_reg));
    end
  end

  // Execution results; a result in the same cycle as a bus write wins.
  always_ff @(posedge aclk) begin
    asdp_sum_s  s;
    logic       to_file;
    logic [7:0] res;
    logic [15:0] pnew;
    to_file = instr_reg[7]; // RL5
    s       = add8(acc_reg, 8'h00, 1'b0);
    res     = 8'h00;
    pnew    = ptr_reg[instr_reg[6]] + {{10{instr_reg[5]}}, instr_reg[5:0]}; // RL1 RL2
    if (!aresetn) begin
      acc_reg       <= `ASDP_ACC_RST;
      flags_reg     <= '0;
      ptr_reg[0]    <= `ASDP_PTR_RST;
      ptr_reg[1]    <= `ASDP_PTR_RST;
      file_out_reg  <= 8'h00;
      file_addr_reg <= 7'h00;
      file_wb_reg   <= 1'b0;
    end else begin
      if (wr_do) begin
        case (awaddr_reg)
          `ASDP_OFF_ACC:    acc_reg <= 8'(merge({24'h000000, acc_reg}, wdata_reg, wstrb_reg));
          `ASDP_OFF_STATUS: flags_reg <= wstrb_reg[0] ? wdata_reg[2:0] : flags_reg;
          `ASDP_OFF_PTR0:   ptr_reg[0] <= 16'(merge({16'h0000, ptr_reg[0]}, wdata_reg,
                                                    wstrb_reg));
          `ASDP_OFF_PTR1:   ptr_reg[1] <= 16'(merge({16'h0000, ptr_reg[1]}, wdata_reg,
                                                    wstrb_reg));
          default: ;
        endcase
      end
      if (state_reg == ASDP_EXEC) begin
        case (instr_reg[13:8])
          {`ASDP_GRP_LIT, `ASDP_NIB_LADD}: begin
            s = add8(acc_reg, instr_reg[7:0], 1'b0);
            acc_reg   <= s.value; // RL3 RL10
            flags_reg <= s.flags; // RL3
          end
          {`ASDP_GRP_LIT, `ASDP_NIB_LAND}: begin
            res = acc_reg & instr_reg[7:0];
            acc_reg     <= res; // RL7 RL11
            flags_reg.z <= res == 8'h00; // RL7
          end
          {`ASDP_GRP_LIT, `ASDP_NIB_PADD}: begin
            if (!instr_reg[7]) begin
              ptr_reg[instr_reg[6]] <= pnew; // RL1 RL2 RL12
            end
          end
          {`ASDP_GRP_LIT, `ASDP_NIB_ADDC}: begin
            s = add8(acc_reg, file_in_reg, flags_reg.c); // RL6
            res       = s.value;
            flags_reg <= s.flags;
          end
          {`ASDP_GRP_LIT, `ASDP_NIB_ASR}: begin
            res = {file_in_reg[7], file_in_reg[7:1]}; // RL9
            flags_reg.c <= file_in_reg[0]; // RL9
            flags_reg.z <= res == 8'h00; // RL9
          end
          {`ASDP_GRP_FILE, `ASDP_NIB_RADD}: begin
            s = add8(acc_reg, file_in_reg, 1'b0); // RL4
            res       = s.value;
            flags_reg <= s.flags;
          end
          {`ASDP_GRP_FILE, `ASDP_NIB_RAND}: begin
            res = acc_reg & file_in_reg; // RL8
            flags_reg.z <= res == 8'h00; // RL8
          end
          default: ;
        endcase
        if (is_file_op(instr_reg)) begin
          file_addr_reg <= instr_reg[6:0];
          file_wb_reg   <= to_file; // RL5
          if (to_file) begin
            file_out_reg <= res; // RL5
          end else begin
            acc_reg <= res; // RL5
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* bench/asdp_monitor.sv */
// Bus handshake checker bound to the add and shift datapath.
`timescale 1ns/1ps
`default_nettype none
module asdp_monitor (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_wready)
    else $error("write answer not released");
  a_wr_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule
bind asdp_core asdp_monitor asdp_monitor_inst (.*);
`default_nettype wire

/* bench/asdp_regfile.sv */
// Register file model standing in for the core's data memory.
`timescale 1ns/1ps
`default_nettype none
module asdp_regfile (
  // Clock.
  input  wire logic       clk,
  // Write port and address.
  input  wire logic       we,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  // Read data.
  output logic      [7:0] rdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
  always @(posedge clk) if (we) mem[addr] <= wdata;
  assign rdata = mem[addr];
endmodule
`default_nettype wire

/* bench/add_and_shift_instr_datapath_tb_top.sv */
// Self-checking bench for the add and shift datapath.
`timescale 1ns/1ps
`default_nettype none
module add_and_shift_instr_datapath_tb_top;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, acc, fo, fin, r, rf_q;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0]  fa, fo_a;
  logic        c, nc, z, wb, rf_we;
  logic [15:0] p [2];
  logic [13:0] op;
  logic [13:0] corner [12] = '{14'h3120, 14'h0700, 14'h315f, 14'h311f, 14'h311f,
                               14'h3eff, 14'h3e01, 14'h3d85, 14'h3900, 14'h3785, 14'h0705,
                               14'h0585};
  logic [5:0]  nib [7] = '{6'h3e, 6'h39, 6'h31, 6'h07, 6'h05, 6'h3d, 6'h37};
  integer      seed = 78655, fail_count = 0, n_compared = 0, cyc = 0;

  asdp_core asdp_core_inst (.*);
  asdp_regfile asdp_regfile_inst (.clk(aclk), .we(rf_we), .addr(fa), .wdata(fo), .rdata(rf_q));

  always #20 aclk = ~aclk;

  function automatic logic [9:0] add3(input logic [7:0] a, b, input logic ci);
    logic [4:0] h;
    h = a[3:0] + b[3:0] + ci;
    return {h[4], {1'b0, a} + b + ci};
  endfunction

  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compared", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (pa && s_axi_awready) s_axi_awvalid <= 0;
      if (pw && s_axi_wready) s_axi_wvalid <= 0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic check_all;
    logic [7:0]  ad [5] = '{8'h0c, 8'h10, 8'h08, 8'h14, 8'h18};
    logic [31:0] e [5];
    e = '{{24'h0, acc}, {27'h0, wb, 1'b0, z, nc, c}, {17'h0, fo_a, fo},
          {16'h0, p[0]}, {16'h0, p[1]}};
    for (int i = 0; i < 5; i++) begin
      rd(ad[i], 2'h0, v);
      chk(v, e[i]);
    end
  endtask

  task automatic run(input logic [13:0] o);
    logic [9:0] s;
    logic [7:0] b;
    logic       rop;
    rop = o[13:8] inside {6'h07, 6'h05, 6'h3d, 6'h37};
    @(posedge aclk);
    fa <= o[6:0];
    @(posedge aclk);
    fin = rf_q;
    wr(8'h04, {24'h0, fin}, 2'h0);
    wr(8'h00, {18'h0, o}, 2'h0);
    v = 32'h8;
    while (v[3]) rd(8'h10, 2'h0, v);
    b = o[13:8] inside {6'h3e, 6'h39} ? o[7:0] : fin;
    s = add3(acc, b, o[13:8] == 6'h3d && c);
    r = acc & b;
    case (o[13:8])
      6'h3e, 6'h07, 6'h3d: {nc, c, r} = s;
      6'h37: {r, c} = {fin[7], fin};
      6'h31: p[o[6]] = p[o[6]] + {{10{o[5]}}, o[5:0]};
      default: ;
    endcase
    if (o[13:8] != 6'h31) z = r == 0;
    if (rop) begin
      wb = o[7];
      fo_a = o[6:0];
    end
    if (rop && o[7]) fo = r;
    else if (o[13:8] != 6'h31) acc = r;
    if (rop && o[7]) begin
      rf_we <= 1;
      @(posedge aclk);
      rf_we <= 0;
    end
    check_all;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, rf_we, fa} = 0;
    {acc, fo, fo_a, c, nc, z, wb} = 0;
    p = '{16'h0, 16'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    check_all;
    rd(8'h40, 2'h2, v);
    chk(v, 0);
    wr(8'h40, 0, 2'h2);
    foreach (corner[i]) run(corner[i]);
    wr(8'h10, 32'h1, 2'h0);
    wr(8'h0c, 32'h3c, 2'h0);
    {z, nc, c} = 3'b001;
    acc = 8'h3c;
    s_axi_wstrb <= 4'h2;
    wr(8'h14, 32'h0000_a5ff, 2'h0);
    s_axi_wstrb <= 4'hf;
    p[0][15:8] = 8'ha5;
    check_all;
    repeat (40) begin
      op = {nib[$unsigned($random(seed)) % 7], 8'($random(seed))};
      if (op[13:8] == 6'h31) op[7] = 0;
      run(op);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
